// >>> hdl/i2c_timing_pkg.sv
package i2c_timing_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h20;
    localparam logic [7:0] OFS_SECOND_ADDR = 8'h0C;
    localparam logic [7:0] OFS_BUS_TIMING = 8'h10;
    localparam logic [7:0] OFS_BUS_TIMEOUT = 8'h14;
    localparam logic [7:0] OFS_ERROR_STATUS = 8'h24;

    localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RESET_SECOND_ADDR = 32'h0000_0000;
    localparam logic [31:0] RESET_BUS_TIMING = 32'h0000_0000;
    localparam logic [31:0] RESET_BUS_TIMEOUT = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_PERIPHERAL_ENABLE = 0;
    localparam int ADDR_VALUE_LSB = 1;
    localparam int ADDR_MASK_LSB = 8;
    localparam int ADDR_ENABLE_BIT = 15;
    localparam int TIM_LOW_LSB = 0;
    localparam int TIM_HIGH_LSB = 8;
    localparam int TIM_HOLD_LSB = 16;
    localparam int TIM_SETUP_LSB = 20;
    localparam int TIM_PSC_LSB = 28;
    localparam int TO_A_LSB = 0;
    localparam int TO_IDLE_BIT = 12;
    localparam int TO_CLK_ENABLE_BIT = 15;
    localparam int TO_B_LSB = 16;
    localparam int TO_EXT_ENABLE_BIT = 31;
    localparam int STAT_TIMEOUT_A_BIT = 0;
    localparam int STAT_EXTENSION_BIT = 1;

    // Writable bits of each register
    localparam logic [31:0] WMASK_CONTROL = 32'h0000_0001;
    localparam logic [31:0] WMASK_SECOND_ADDR = 32'h0000_80FE;
    localparam logic [31:0] WMASK_ADDR_MASK_FIELD = 32'h0000_0700;
    localparam logic [31:0] WMASK_BUS_TIMING = 32'hF0FF_FFFF;
    localparam logic [31:0] WMASK_TO_A_FIELDS = 32'h0000_1FFF;
    localparam logic [31:0] WMASK_TO_CLK_ENABLE = 32'h0000_8000;
    localparam logic [31:0] WMASK_TO_B_FIELD = 32'h0FFF_0000;
    localparam logic [31:0] WMASK_TO_EXT_ENABLE = 32'h8000_0000;

    // ----------------------------------------------------------------
    // Timing units and codes
    // ----------------------------------------------------------------
    localparam int LOW_TIMEOUT_UNIT = 2048;
    localparam int IDLE_TIMEOUT_UNIT = 4;
    localparam int EXTENSION_UNIT = 2048;
    localparam logic [2:0] MASK_NO_COMPARE = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLAVE_ERROR = 2'h2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } addrRequest_t;

    typedef struct packed {
        logic ack;
        logic nack;
    } addrAnswer_t;

    typedef enum logic [1:0] {
        SCL_IDLE,
        SCL_LOW,
        SCL_HIGH
    } sclPhase_t;

endpackage

// >>> hdl/second_own_address_timing_timeout.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module second_own_address_timing_timeout
    import i2c_timing_pkg::*;
#(
    parameter int LOW_UNIT = LOW_TIMEOUT_UNIT,
    parameter int IDLE_UNIT = IDLE_TIMEOUT_UNIT,
    parameter int EXT_UNIT = EXTENSION_UNIT
) (
    input wire logic clk, // Kernel clock, 20 MHz
    input wire logic rst_n, // Synchronous reset
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte lanes
    output logic [31:0] readdata, // Avalon read data
    output logic [1:0] response, // Avalon response
    output logic waitrequest, // Avalon wait
    input wire addrRequest_t addrReq, // Received address, one-cycle valid
    output addrAnswer_t addrAnswer, // Ack or nack pulse for second address
    input wire logic masterRun, // Master wants SCL clocking
    input wire logic masterMode, // Device acting as master
    input wire logic slaveStretch, // Slave logic holding SCL low
    input wire logic frameActive, // Transfer in progress
    input wire logic sclIn, // SCL wire level
    input wire logic sdaIn, // SDA wire level
    output logic sclOe_n, // Low while driving SCL low
    output logic sdaUpdate, // Pulse: SDA may change now
    output logic peripheralEnable, // Peripheral enable level
    output logic timeoutError // Any sticky timeout flag
);

    if (LOW_UNIT < 2 || LOW_UNIT > 2048 || IDLE_UNIT < 2 || IDLE_UNIT > 2048
        || EXT_UNIT < 2 || EXT_UNIT > 2048) begin
        $error("Timeout units must lie in 2..2048");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] control;
        logic [31:0] secondAddr;
        logic [31:0] busTiming;
        logic [31:0] busTimeout;
        logic flagA;
        logic flagB;
        logic waitReq;
        logic [31:0] rdata;
        logic [1:0] resp;
        addrAnswer_t answer;
        logic [3:0] pscCnt;
        sclPhase_t phase;
        logic [8:0] phaseCnt;
        logic [3:0] holdCnt;
        logic [4:0] setupCnt;
        logic updated;
        logic sclDrive;
        logic sdaPulse;
        logic [10:0] aUnit;
        logic [11:0] aBlock;
        logic aDone;
        logic [10:0] bUnit;
        logic [11:0] bBlock;
        logic bDone;
    } state_t;

    localparam state_t STATE_RESET = '{
        control: RESET_CONTROL,
        secondAddr: RESET_SECOND_ADDR,
        busTiming: RESET_BUS_TIMING,
        busTimeout: RESET_BUS_TIMEOUT,
        waitReq: 1'b1,
        phase: SCL_IDLE,
        default: '0
    };

    localparam logic [10:0] LOW_LAST = 11'(LOW_UNIT - 1);
    localparam logic [10:0] IDLE_LAST = 11'(IDLE_UNIT - 1);
    localparam logic [10:0] EXT_LAST = 11'(EXT_UNIT - 1);

    state_t st;
    state_t next_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] be, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old & ~m) | (data & m);
    endfunction

    function automatic logic addrMatches(input logic [6:0] rx, input logic [6:0] own,
                                         input logic [2:0] code);
        logic [6:0] care;
        logic reserved;
        care = 7'h7F << code;
        reserved = (rx[6:3] == 4'h0) || (rx[6:3] == 4'hF);
        if (code != 3'h0 && reserved) begin
            return 1'b0;
        end
        if (code == MASK_NO_COMPARE) begin
            return 1'b1;
        end
        return ((rx ^ own) & care) == 7'h00;
    endfunction

    // Compares unit and block counts; true when the final block of the limit ends
    function automatic logic blockStep(input logic [10:0] unit, input logic [11:0] blk,
                                       input logic [10:0] last, input logic [11:0] limit);
        return (unit == last) && (blk == limit);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic en;
    logic tick;
    logic busReq;
    logic wrAccept;
    logic sdaDone;
    logic [6:0] ownAddr;
    logic [2:0] maskCode;
    logic [7:0] lowCount;
    logic [7:0] highCount;
    logic [3:0] holdCount;
    logic [3:0] setupCount;
    logic [3:0] prescaler;
    logic [11:0] limitA;
    logic [11:0] limitB;
    logic idleSel;
    logic clock_timeout_enable;
    logic extToEn;
    logic condA;
    logic condB;
    logic [10:0] lastA;
    logic [31:0] clearMask;

    always_comb begin
        next_st = st;
        en = st.control[CTRL_PERIPHERAL_ENABLE];
        ownAddr = st.secondAddr[ADDR_VALUE_LSB +: 7];
        maskCode = st.secondAddr[ADDR_MASK_LSB +: 3];
        lowCount = st.busTiming[TIM_LOW_LSB +: 8];
        highCount = st.busTiming[TIM_HIGH_LSB +: 8];
        holdCount = st.busTiming[TIM_HOLD_LSB +: 4];
        setupCount = st.busTiming[TIM_SETUP_LSB +: 4];
        prescaler = st.busTiming[TIM_PSC_LSB +: 4];
        limitA = st.busTimeout[TO_A_LSB +: 12];
        idleSel = st.busTimeout[TO_IDLE_BIT];
        clock_timeout_enable = st.busTimeout[TO_CLK_ENABLE_BIT];
        limitB = st.busTimeout[TO_B_LSB +: 12];
        extToEn = st.busTimeout[TO_EXT_ENABLE_BIT];
        busReq = read || write;
        wrAccept = write && !st.waitReq;
        clearMask = '0;

        // --------------------------------------------------------------
        // Avalon slave: one wait cycle, then answer
        // --------------------------------------------------------------
        next_st.waitReq = !(busReq && st.waitReq);
        if (busReq && st.waitReq) begin
            next_st.resp = RESP_OKAY;
            unique case (address)
                OFS_CONTROL: next_st.rdata = st.control;
                OFS_SECOND_ADDR: next_st.rdata = st.secondAddr;
                OFS_BUS_TIMING: next_st.rdata = st.busTiming;
                OFS_BUS_TIMEOUT: next_st.rdata = st.busTimeout;
                OFS_ERROR_STATUS: begin
                    next_st.rdata = '0;
                    next_st.rdata[STAT_TIMEOUT_A_BIT] = st.flagA;
                    next_st.rdata[STAT_EXTENSION_BIT] = st.flagB;
                end
                default: begin
                    next_st.rdata = '0;
                    next_st.resp = RESP_SLAVE_ERROR;
                end
            endcase
        end
        if (wrAccept) begin
            unique case (address)
                OFS_CONTROL: begin
                    next_st.control = merge(st.control, writedata, byteenable, WMASK_CONTROL);
                end
                OFS_SECOND_ADDR: begin
                    next_st.secondAddr = merge(st.secondAddr, writedata, byteenable,
                        st.secondAddr[ADDR_ENABLE_BIT] ? WMASK_SECOND_ADDR
                        : (WMASK_SECOND_ADDR | WMASK_ADDR_MASK_FIELD));
                end
                OFS_BUS_TIMING: begin
                    if (!en) begin
                        next_st.busTiming = merge(st.busTiming, writedata, byteenable,
                            WMASK_BUS_TIMING);
                    end
                end
                OFS_BUS_TIMEOUT: begin
                    next_st.busTimeout = merge(st.busTimeout, writedata, byteenable,
                        WMASK_TO_CLK_ENABLE | WMASK_TO_EXT_ENABLE
                        | (clock_timeout_enable ? 32'h0000_0000 : WMASK_TO_A_FIELDS)
                        | (extToEn ? 32'h0000_0000 : WMASK_TO_B_FIELD));
                end
                OFS_ERROR_STATUS: begin
                    clearMask = writedata & {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Second own address match
        // --------------------------------------------------------------
        next_st.answer = '0;
        if (en && addrReq.valid && addrMatches(addrReq.addr, ownAddr, maskCode)) begin
            next_st.answer.ack = st.secondAddr[ADDR_ENABLE_BIT];
            next_st.answer.nack = !st.secondAddr[ADDR_ENABLE_BIT];
        end

        // --------------------------------------------------------------
        // Timing tick and master SCL generator
        // --------------------------------------------------------------
        tick = en && (st.pscCnt == prescaler);
        next_st.pscCnt = tick ? 4'h0 : st.pscCnt + 4'h1;
        next_st.sdaPulse = 1'b0;
        sdaDone = st.updated && (st.setupCnt == 5'(setupCount) + 5'h01);
        unique case (st.phase)
            SCL_IDLE: begin
                next_st.sclDrive = 1'b0;
                if (masterRun) begin
                    next_st.phase = SCL_LOW;
                    next_st.sclDrive = 1'b1;
                    next_st.phaseCnt = '0;
                    next_st.holdCnt = '0;
                    next_st.setupCnt = '0;
                    next_st.updated = 1'b0;
                end
            end
            SCL_LOW: begin
                if (tick && st.phaseCnt <= 9'(lowCount)) begin
                    next_st.phaseCnt = st.phaseCnt + 9'h001;
                end
                if (!st.updated) begin
                    if (st.holdCnt == holdCount) begin
                        next_st.updated = 1'b1;
                        next_st.sdaPulse = 1'b1;
                    end else if (tick) begin
                        next_st.holdCnt = st.holdCnt + 4'h1;
                    end
                end else if (tick && !sdaDone) begin
                    next_st.setupCnt = st.setupCnt + 5'h01;
                end
                if (st.phaseCnt == 9'(lowCount) + 9'h001 && sdaDone) begin
                    next_st.phase = SCL_HIGH;
                    next_st.sclDrive = 1'b0;
                    next_st.phaseCnt = '0;
                end
            end
            SCL_HIGH: begin
                // High time counts only once the wire is really high
                if (tick && sclIn) begin
                    next_st.phaseCnt = st.phaseCnt + 9'h001;
                end
                if (st.phaseCnt == 9'(highCount) + 9'h001) begin
                    next_st.phase = masterRun ? SCL_LOW : SCL_IDLE;
                    next_st.sclDrive = masterRun;
                    next_st.phaseCnt = '0;
                    next_st.holdCnt = '0;
                    next_st.setupCnt = '0;
                    next_st.updated = 1'b0;
                end
            end
            default: begin
                next_st.phase = SCL_IDLE;
            end
        endcase

        // --------------------------------------------------------------
        // Timeout A: SCL low or bus idle
        // --------------------------------------------------------------
        condA = clock_timeout_enable && (idleSel ? (sclIn && sdaIn) : !sclIn);
        lastA = idleSel ? IDLE_LAST : LOW_LAST;
        if (!condA) begin
            next_st.aUnit = '0;
            next_st.aBlock = '0;
            next_st.aDone = 1'b0;
        end else if (!st.aDone) begin
            if (blockStep(st.aUnit, st.aBlock, lastA, limitA)) begin
                next_st.aDone = 1'b1;
            end else if (st.aUnit == lastA) begin
                next_st.aUnit = '0;
                next_st.aBlock = st.aBlock + 12'h001;
            end else begin
                next_st.aUnit = st.aUnit + 11'h001;
            end
        end

        // --------------------------------------------------------------
        // Timeout B: accumulated clock-low extension per frame
        // --------------------------------------------------------------
        condB = masterMode ? st.sclDrive : slaveStretch;
        if (!frameActive || !extToEn) begin
            next_st.bUnit = '0;
            next_st.bBlock = '0;
            next_st.bDone = 1'b0;
        end else if (condB && !st.bDone) begin
            if (blockStep(st.bUnit, st.bBlock, EXT_LAST, limitB)) begin
                next_st.bDone = 1'b1;
            end else if (st.bUnit == EXT_LAST) begin
                next_st.bUnit = '0;
                next_st.bBlock = st.bBlock + 12'h001;
            end else begin
                next_st.bUnit = st.bUnit + 11'h001;
            end
        end

        // --------------------------------------------------------------
        // Sticky flags: hardware set wins over software clear
        // --------------------------------------------------------------
        next_st.flagA = (st.flagA && !clearMask[STAT_TIMEOUT_A_BIT])
            || (next_st.aDone && !st.aDone);
        next_st.flagB = (st.flagB && !clearMask[STAT_EXTENSION_BIT])
            || (next_st.bDone && !st.bDone);

        // --------------------------------------------------------------
        // Disabled peripheral holds all counters clear
        // --------------------------------------------------------------
        if (!en) begin
            next_st.pscCnt = '0;
            next_st.phase = SCL_IDLE;
            next_st.phaseCnt = '0;
            next_st.holdCnt = '0;
            next_st.setupCnt = '0;
            next_st.updated = 1'b0;
            next_st.sclDrive = 1'b0;
            next_st.sdaPulse = 1'b0;
            next_st.aUnit = '0;
            next_st.aBlock = '0;
            next_st.aDone = 1'b0;
            next_st.bUnit = '0;
            next_st.bBlock = '0;
            next_st.bDone = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign readdata = st.rdata;
    assign response = st.resp;
    assign waitrequest = st.waitReq;
    assign addrAnswer = st.answer;
    assign sclOe_n = !st.sclDrive;
    assign sdaUpdate = st.sdaPulse;
    assign peripheralEnable = st.control[CTRL_PERIPHERAL_ENABLE];
    assign timeoutError = st.flagA || st.flagB;

endmodule

// >>> verification/i2c_bus_partner.sv
`timescale 1ns/1ps
module i2c_bus_partner (
    input wire logic sclOe_n, // Device pulls SCL when low
    input wire logic holdLow, // Other party stretches SCL
    output logic sclIn, // Resolved SCL wire
    output logic sdaIn // Resolved SDA wire
);
    // ------------------------------------------------------------
    // Open-drain wires, pull-ups, SDA released by all
    // ------------------------------------------------------------
    assign sclIn = sclOe_n & ~holdLow;
    assign sdaIn = 1'h1;
endmodule

// >>> verification/i2c_timing_checker.sv
`timescale 1ns/1ps
module i2c_timing_checker
    import i2c_timing_pkg::*;
(
    input wire logic clk, // Kernel clock
    input wire logic rst_n, // Sync reset
    input wire logic [7:0] address, // Bus address
    input wire logic write, // Bus write
    input wire logic waitrequest, // Bus wait
    input wire addrRequest_t addrReq, // Received address
    input wire addrAnswer_t addrAnswer, // Ack or nack
    input wire logic sclOe_n, // SCL drive
    input wire logic sdaUpdate, // SDA change pulse
    input wire logic peripheralEnable, // Enable level
    input wire logic timeoutError // Sticky timeout
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    answer_cause_a: assert property (
        (addrAnswer.ack || addrAnswer.nack) |-> $past(addrReq.valid && peripheralEnable))
        else $error("Answer without a request");
    answer_excl_a: assert property (!(addrAnswer.ack && addrAnswer.nack))
        else $error("Ack and nack together");
    answer_off_a: assert property (
        addrReq.valid && !peripheralEnable |=> addrAnswer == 2'h0)
        else $error("Answer while disabled");
    scl_off_a: assert property (
        !peripheralEnable && $past(!peripheralEnable) |-> sclOe_n)
        else $error("SCL driven while disabled");
    sda_window_a: assert property (sdaUpdate |-> !sclOe_n ##1 !sclOe_n)
        else $error("SDA change outside low phase");
    scl_low_min_a: assert property ($fell(sclOe_n) |-> !sclOe_n [*2])
        else $error("SCL low phase too short");
    error_sticky_a: assert property ($fell(timeoutError) |->
        $past(write && !waitrequest && address == OFS_ERROR_STATUS) || $past(!peripheralEnable))
        else $error("Timeout flag dropped by itself");
    error_rise_a: assert property ($rose(timeoutError) |-> $past(peripheralEnable))
        else $error("Timeout while disabled");
    wait_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("Wait low longer than one cycle");
    cover property (addrAnswer.ack);
    cover property (addrAnswer.nack);
    cover property ($rose(timeoutError));
    cover property (sdaUpdate);
endmodule

bind second_own_address_timing_timeout i2c_timing_checker chk (.clk(clk), .rst_n(rst_n), .address(address),
    .write(write), .waitrequest(waitrequest), .addrReq(addrReq), .addrAnswer(addrAnswer),
    .sclOe_n(sclOe_n), .sdaUpdate(sdaUpdate), .peripheralEnable(peripheralEnable),
    .timeoutError(timeoutError));

// >>> verification/second_own_address_timing_timeout_tb.sv
`timescale 1ns/1ps
module second_own_address_timing_timeout_tb;
    import i2c_timing_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] address = 8'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;
    logic [1:0] response;
    logic waitrequest, sclOe_n, sdaUpdate, peripheralEnable, timeoutError, sclIn, sdaIn;
    addrRequest_t addrReq = '0;
    addrAnswer_t addrAnswer;
    logic masterRun = 1'h0;
    logic slaveStretch = 1'h0;
    logic frameActive = 1'h0;
    logic holdLow = 1'h0;
    int miscompares = 0;
    int checks = 0;
    int lo, hi, sd;
    always #25 clk = ~clk;
    second_own_address_timing_timeout #(.LOW_UNIT(4), .IDLE_UNIT(2), .EXT_UNIT(4)) uut (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .addrReq(addrReq), .addrAnswer(addrAnswer),
        .masterRun(masterRun), .masterMode(1'h0), .slaveStretch(slaveStretch),
        .frameActive(frameActive), .sclIn(sclIn), .sdaIn(sdaIn), .sclOe_n(sclOe_n),
        .sdaUpdate(sdaUpdate), .peripheralEnable(peripheralEnable),
        .timeoutError(timeoutError));
    i2c_bus_partner partner (.sclOe_n(sclOe_n), .holdLow(holdLow), .sclIn(sclIn), .sdaIn(sdaIn));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rng(input string what, input int lo_b, input int hi_b, input int got);
        checks++;
        if (got < lo_b || got > hi_b) begin
            miscompares++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo_b, hi_b, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n = 0;
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'h0 && n < 50);
        r = readdata;
        write <= 1'h0;
        read <= 1'h0;
        @(posedge clk);
        if (n >= 50) check("waitrequest", 32'h0, 32'h1);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        check(what, exp, r);
    endtask
    task automatic send(input logic [6:0] a, input logic [1:0] exp);
        addrReq <= {1'h1, a};
        @(posedge clk);
        addrReq <= '0;
        @(negedge clk);
        check("addrAnswer", {30'h0, exp}, {30'h0, addrAnswer});
        @(posedge clk);
    endtask
    task automatic phase(input logic lvl, output int len, output int sdAt);
        int n = 0;
        len = 0;
        sdAt = 0;
        while (sclOe_n !== lvl && n < 99) begin
            @(posedge clk);
            n++;
        end
        while (sclOe_n === lvl && len < 99) begin
            len++;
            if (sdaUpdate === 1'h1 && sdAt == 0) sdAt = len;
            @(posedge clk);
        end
    endtask
    task automatic to_error(input string what);
        int n = 0;
        while (timeoutError !== 1'h1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        rng(what, 8, 11, n);
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rdchk("addrReg", OFS_SECOND_ADDR, 32'h0);
        rdchk("timingReg", OFS_BUS_TIMING, 32'h0);
        rdchk("timeoutReg", OFS_BUS_TIMEOUT, 32'h0);
        rdchk("unmapped", 8'h30, 32'h0);
        check("response", {30'h0, RESP_SLAVE_ERROR}, {30'h0, response});
        $display("test reset done");
    endtask
    task automatic test_addr;
        bus(1'h1, OFS_CONTROL, 32'h1, q);
        bus(1'h1, OFS_SECOND_ADDR, 32'h80A5, q);
        rdchk("addrReg", OFS_SECOND_ADDR, 32'h80A4);
        send(7'h52, 2'h2);
        send(7'h53, 2'h0);
        bus(1'h1, OFS_SECOND_ADDR, 32'h83A4, q);
        rdchk("maskLocked", OFS_SECOND_ADDR, 32'h80A4);
        bus(1'h1, OFS_SECOND_ADDR, 32'h03A4, q);
        bus(1'h1, OFS_SECOND_ADDR, 32'h03A4, q);
        rdchk("maskOpen", OFS_SECOND_ADDR, 32'h03A4);
        send(7'h52, 2'h1);
        bus(1'h1, OFS_SECOND_ADDR, 32'h83A4, q);
        send(7'h55, 2'h2);
        send(7'h62, 2'h0);
        bus(1'h1, OFS_SECOND_ADDR, 32'h07A4, q);
        bus(1'h1, OFS_SECOND_ADDR, 32'h87A4, q);
        send(7'h33, 2'h2);
        send(7'h7C, 2'h0);
        send(7'h05, 2'h0);
        $display("test addr done");
    endtask
    task automatic test_timing;
        bus(1'h1, OFS_BUS_TIMING, 32'h1001_0103, q);
        rdchk("timingLocked", OFS_BUS_TIMING, 32'h0);
        bus(1'h1, OFS_CONTROL, 32'h0, q);
        send(7'h33, 2'h0);
        bus(1'h1, OFS_BUS_TIMING, 32'h1001_0103, q);
        rdchk("timingOpen", OFS_BUS_TIMING, 32'h1001_0103);
        bus(1'h1, OFS_CONTROL, 32'h1, q);
        masterRun <= 1'h1;
        phase(1'h0, lo, sd);
        phase(1'h1, hi, sd);
        phase(1'h0, lo, sd);
        masterRun <= 1'h0;
        rng("sclHighClocks", 4, 6, hi);
        rng("sclLowClocks", 8, 10, lo);
        rng("sdaDelayClocks", 2, 5, sd);
        repeat (40) @(posedge clk);
        check("sclOe_n", 32'h1, {31'h0, sclOe_n});
        $display("test timing done");
    endtask
    task automatic test_timeout;
        check("idleDisabled", 32'h0, {31'h0, timeoutError});
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h9003, q);
        to_error("idleClocks");
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h8005, q);
        rdchk("timeoutLocked", OFS_BUS_TIMEOUT, 32'h9003);
        rdchk("status", OFS_ERROR_STATUS, 32'h1);
        bus(1'h1, OFS_ERROR_STATUS, 32'h1, q);
        repeat (20) @(posedge clk);
        check("noRefire", 32'h0, {31'h0, timeoutError});
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h0, q);
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h8001, q);
        holdLow <= 1'h1;
        to_error("lowClocks");
        holdLow <= 1'h0;
        bus(1'h1, OFS_ERROR_STATUS, 32'h3, q);
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h0, q);
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h0001_0000, q);
        slaveStretch <= 1'h1;
        frameActive <= 1'h1;
        repeat (30) @(posedge clk);
        check("extDisabled", 32'h0, {31'h0, timeoutError});
        frameActive <= 1'h0;
        bus(1'h1, OFS_BUS_TIMEOUT, 32'h8001_0000, q);
        frameActive <= 1'h1;
        to_error("extClocks");
        slaveStretch <= 1'h0;
        frameActive <= 1'h0;
        $display("test timeout done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        test_reset();
        test_addr();
        test_timing();
        test_timeout();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule
